// *** dv/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench import uoc_pkg::*; ;
   localparam int MS = 20;
   localparam int LIMIT = 20000;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic role_id_pin = 1'b0;
   logic otg_feature_req = 1'b0;
   logic bus_reset_seen = 1'b0;
   logic attached = 1'b0;
   logic low_spd = 1'b0;
   logic stuck_hi = 1'b0;
   logic dp_in, dm_in, otg_feature_ack, otg_feature_stall;
   logic [1:0] engine1_mode, engine2_mode, resp;
   logic engine1_speed, engine2_speed;
   logic [15:0] engine1_dev_desc_pointer, engine2_dev_desc_pointer;
   logic [1:0] pu_seen = 2'b00;
   logic [31:0] st;
   uoc_axil_req_t axil_req = '0;
   uoc_axil_rsp_t axil_rsp;
   uoc_usb_drv_t usb_drv;
   int num_errors = 0;
   int num_checks = 0;
   int cyc, k_len, se0_run, se0_max, sof_n, eop_n;

   uoc_port_ctrl #(.MS_CYCLES(MS)) i_uoc_port_ctrl (
      .clk_sys, .reset_n, .clk_en(1'b1), .axil_req, .axil_rsp, .dp_in,
      .dm_in, .role_id_pin, .standalone_mode(1'b1), .otg_feature_req,
      .otg_feature_ack, .otg_feature_stall, .bus_reset_seen, .usb_drv,
      .engine1_mode, .engine2_mode, .engine1_speed, .engine2_speed,
      .engine1_dev_desc_pointer, .engine2_dev_desc_pointer
   );
   uoc_usb_dev i_uoc_usb_dev (
      .usb_drv, .attached, .low_spd, .stuck_hi, .dp_in, .dm_in
   );

   always #5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         num_errors++;
         test_done();
      end
      if (usb_drv.drive_k)
         k_len <= k_len + 1;
      if (usb_drv.drive_se0 && se0_run == 0)
         eop_n <= eop_n + 1;
      se0_run <= usb_drv.drive_se0 ? se0_run + 1 : 0;
      if (se0_run > se0_max)
         se0_max <= se0_run;
      if (usb_drv.sof_mark)
         sof_n <= sof_n + 1;
      if (usb_drv.vbus_drive)
         pu_seen <= pu_seen | {usb_drv.dm_pullup, usb_drv.dp_pullup};
   end

   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      axil_req.awaddr <= {24'h000000, a};
      axil_req.wdata <= d;
      axil_req.wstrb <= 4'hF;
      axil_req.awvalid <= 1'b1;
      axil_req.wvalid <= 1'b1;
      axil_req.bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (axil_rsp.awready)
            axil_req.awvalid <= 1'b0;
         if (axil_rsp.wready)
            axil_req.wvalid <= 1'b0;
      end while (!axil_rsp.bvalid);
      axil_req.bready <= 1'b0;
      resp = axil_rsp.bresp;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      axil_req.araddr <= {24'h000000, a};
      axil_req.arvalid <= 1'b1;
      axil_req.rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (axil_rsp.arready)
            axil_req.arvalid <= 1'b0;
      end while (!axil_rsp.rvalid);
      axil_req.rready <= 1'b0;
      d = axil_rsp.rdata;
      resp = axil_rsp.rresp;
   endtask : rd

   // Polling clears the descriptor-reject flag, so check it before runs
   task automatic run(input logic [3:0] op, input logic [31:0] arg);
      wr(A_ARG, arg);
      wr(A_CMD, {28'h0000000, op});
      st = 32'h00000001;
      while (st[0])
         rd(A_STATUS, st);
   endtask : run

   // Cleared between edges so no monitor update is lost
   task automatic clr();
      @(negedge clk_sys);
      k_len = 0;
      se0_max = 0;
      sof_n = 0;
      eop_n = 0;
      pu_seen = 2'b00;
   endtask : clr

   task automatic feat(input logic [1:0] e);
      otg_feature_req <= 1'b1;
      @(posedge clk_sys);
      otg_feature_req <= 1'b0;
      @(posedge clk_sys);
      chk("feat", e, {otg_feature_ack, otg_feature_stall});
   endtask : feat

   initial begin
      clr();
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (20) @(posedge clk_sys);
      chk("e1_mode", MODE_HOST, engine1_mode);
      chk("e2_mode", MODE_PERIPH, engine2_mode);
      chk("e2_spd", SPEED_FULL, engine2_speed);
      feat(2'b01);
      wr(A_OTG_DESC, 32'h00000200);
      feat(2'b10);
      wr(A_DESC1, 32'h00011234);
      rd(A_STATUS, st);
      chk("rej_host", 1, st[8]);
      chk("ptr_host", 0, engine1_dev_desc_pointer);
      for (int s = 0; s < 2; s++) begin
         clr();
         run(OP_SRP, {15'h0000, s[0], 16'h0003});
         chk("srp_line", s[0] ? 2'b10 : 2'b01, pu_seen);
         chk("srp_res", 0, st[1]);
         chk("srp_off", 0, {usb_drv.vbus_drive, usb_drv.dp_pullup,
                            usb_drv.dm_pullup});
      end
      for (int m = 0; m < 32; m += 31) begin
         run(OP_SRP, m);
         chk("srp_ms", 1, st[1]);
      end
      // Stuck line would fail the check, so zero proves the early exit
      role_id_pin <= 1'b1;
      stuck_hi <= 1'b1;
      fork
         run(OP_SRP, 32'h00000005);
         begin
            repeat (40) @(posedge clk_sys);
            role_id_pin <= 1'b0;
         end
      join
      chk("abort_res", 0, st[1]);
      chk("abort_vbus", 0, usb_drv.vbus_drive);
      run(OP_SRP, 32'h00000002);
      chk("srp_err", 1, st[1]);
      stuck_hi <= 1'b0;
      run(OP_WAKE, 32'h00000000);
      chk("wake_e1", 1, st[1]);
      clr();
      run(OP_WAKE, 32'h00000100);
      chk("wake_res", 0, st[1]);
      chk("k_len", 10 * MS, k_len);
      run(OP_PERIPH, 32'h00010100);
      chk("e1_periph", MODE_PERIPH, engine1_mode);
      chk("e1_spd", SPEED_LOW, engine1_speed);
      run(OP_PERIPH, 32'h00000300);
      chk("sel_bad", 1, st[1]);
      bus_reset_seen <= 1'b1;
      @(posedge clk_sys);
      bus_reset_seen <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("spd_keep", SPEED_LOW, engine1_speed);
      wr(A_DESC1, 32'h00025678);
      rd(A_STATUS, st);
      chk("rej_cnt", 1, st[8]);
      wr(A_DESC1, 32'h00011234);
      rd(A_STATUS, st);
      chk("rej_ok", 0, st[8]);
      chk("ptr1", 16'h1234, engine1_dev_desc_pointer);
      for (int c = 0; c < 3; c++) begin
         attached <= c != 0;
         low_spd <= c == 1;
         clr();
         run(OP_HRESET, {22'h000000, c == 0 ? 2'h0 : c[1:0] + 2'h1, 8'h05});
         chk("se0_len", 1, se0_max >= 10 * MS && se0_max < 11 * MS);
         chk("port_sel", c == 0 ? 0 : c + 1, usb_drv.port_sel);
         rd(A_PORT, st);
         chk("port_st", c == 0 ? 2 : c == 1 ? 1 : 0, st);
         clr();
         repeat (3 * MS) @(posedge clk_sys);
         chk("sof", c == 2, sof_n >= 2 && sof_n <= 4);
         chk("eop", c == 1, eop_n > 0);
      end
      wr(A_DESC2, 32'h00015678);
      chk("ptr2", 16'h5678, engine2_dev_desc_pointer);
      run(OP_HOST1, 32'h00000000);
      chk("e1_host", MODE_HOST, engine1_mode);
      run(OP_HOST2, 32'h00000000);
      chk("e2_host", MODE_HOST, engine2_mode);
      rd(8'h40, st);
      chk("unmap_d", 0, st);
      chk("unmap_r", RESP_SLVERR, resp);
      wr(8'h44, 32'hFFFFFFFF);
      chk("unmap_w", RESP_SLVERR, resp);
      test_done();
   end
endmodule : testbench
`default_nettype wire

// *** dv/uoc_usb_dev.sv ***
`timescale 1ns/1ns
`default_nettype none
module uoc_usb_dev import uoc_pkg::*; (
   input wire uoc_usb_drv_t usb_drv,
   input wire logic attached,
   input wire logic low_spd,
   input wire logic stuck_hi,
   output var logic dp_in,
   output var logic dm_in
);
   // Device pull-up marks its speed; host pull-downs win when detached
   always_comb begin
      dp_in = attached && !low_spd;
      dm_in = attached && low_spd;
      if (usb_drv.dp_pullup)
         dp_in = 1'b1;
      if (usb_drv.dm_pullup)
         dm_in = 1'b1;
      if (usb_drv.drive_k) begin
         dp_in = 1'b0;
         dm_in = 1'b1;
      end
      if (usb_drv.drive_se0) begin
         dp_in = 1'b0;
         dm_in = 1'b0;
      end
      // Faulty line held high, only when a test asks for it
      if (stuck_hi)
         dp_in = 1'b1;
   end
endmodule : uoc_usb_dev
`default_nettype wire

// *** src/uoc_pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module uoc_pin_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [W-1:0] pin_in,
   output var logic [W-1:0] pin_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] stable;
   } uoc_sync_st_t;

   uoc_sync_st_t q, d;

   always_comb begin
      d = q;
      d.s1 = pin_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // Only bits whose later stages agree may move
      d.stable = (q.s2 & ~(q.s2 ^ q.s3)) | (q.stable & (q.s2 ^ q.s3));
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign pin_out = q.stable;
endmodule : uoc_pin_sync
`default_nettype wire

// *** src/uoc_pkg.sv ***
// Overview of operation
// [RQ1] Zero OTG pointer after reset; stall feature
// [RQ2] Nonzero OTG pointer acknowledges feature request
// [RQ3] Session request pulses VBUS and one line
// [RQ4] Requester gives pulse 1 to 30 ms
// [RQ5] Speed select: 0 full D+, 1 low D-
// [RQ6] ID falling during pulse aborts, result zero
// [RQ7] Pull lines down; high line reports error
// [RQ8] Session request ends with drives off
// [RQ9] Requester turns drives off before starting
// [RQ10] Remote wakeup drives K for 10 ms
// [RQ11] Wakeup select 0 first engine; result zero ok
// [RQ12] Stand-alone, ID low: engine one is host
// [RQ13] ID high: engine one peripheral; two always
// [RQ14] Port reset holds SE0 at least 10 ms
// [RQ15] Reset peripherals answer at address zero
// [RQ16] Port status: bit0 low, bit1 no device
// [RQ17] Keep-alive SOF full, EOP low, else none
// [RQ18] Port reset selects one of four ports
// [RQ19] Peripheral enable: speed and engine number
// [RQ20] Bus reset reapplies user chosen speed
// [RQ21] Descriptor pointer taken only when engine enabled
// [RQ22] Descriptor must report exactly one configuration
// [RQ23] Durations timed by a millisecond tick
package uoc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYC_DEF = MS_NS / CLK_PERIOD_NS;
   localparam int unsigned MS_CNT_W = 17;
   localparam logic [7:0] WAKE_MS = 8'h0A;
   localparam logic [7:0] RESET_MIN_MS = 8'h0A;
   localparam logic [7:0] SRP_MAX_MS = 8'h1E;
   localparam logic [7:0] SETTLE_MS = 8'h01;
   localparam logic [7:0] BOOT_CYC = 8'h08;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_ARG = 8'h04;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_PORT = 8'h0C;
   localparam logic [7:0] A_OTG_DESC = 8'h10;
   localparam logic [7:0] A_DESC1 = 8'h14;
   localparam logic [7:0] A_DESC2 = 8'h18;
   localparam logic [3:0] OP_SRP = 4'h1;
   localparam logic [3:0] OP_WAKE = 4'h2;
   localparam logic [3:0] OP_HRESET = 4'h3;
   localparam logic [3:0] OP_PERIPH = 4'h4;
   localparam logic [3:0] OP_HOST1 = 4'h5;
   localparam logic [3:0] OP_HOST2 = 4'h6;
   localparam int ARG_SEL_LSB = 8;
   localparam int ARG_SPD_BIT = 16;
   localparam int DESC_CNT_LSB = 16;
   localparam logic [7:0] ENG_ONE = 8'h01;
   localparam logic [7:0] ENG_TWO = 8'h02;
   localparam logic [7:0] SEL_FIRST = 8'h00;
   localparam logic [3:0] CFG_COUNT_ONE = 4'h1;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_HOST = 2'h1;
   localparam logic [1:0] MODE_PERIPH = 2'h2;
   localparam logic SPEED_FULL = 1'b0;
   localparam logic SPEED_LOW = 1'b1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [6:0] {
      ST_BOOT = 7'h01,
      ST_IDLE = 7'h02,
      ST_SRP_PULSE = 7'h04,
      ST_SRP_CHECK = 7'h08,
      ST_WAKE = 7'h10,
      ST_RST_HOLD = 7'h20,
      ST_SPEED = 7'h40
   } uoc_state_t;

   typedef struct packed {
      logic [31:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [31:0] araddr;
      logic arvalid;
      logic rready;
   } uoc_axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } uoc_axil_rsp_t;

   typedef struct packed {
      logic vbus_drive;
      logic dp_pullup;
      logic dm_pullup;
      logic dp_pulldown;
      logic dm_pulldown;
      logic drive_se0;
      logic drive_k;
      logic sof_mark;
      logic [1:0] port_sel;
   } uoc_usb_drv_t;
endpackage : uoc_pkg

// *** src/uoc_port_ctrl.sv ***
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module uoc_port_ctrl import uoc_pkg::*; #(
   parameter int unsigned MS_CYCLES = MS_CYC_DEF
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire uoc_axil_req_t axil_req,
   output var uoc_axil_rsp_t axil_rsp,
   input wire logic dp_in,
   input wire logic dm_in,
   input wire logic role_id_pin,
   input wire logic standalone_mode,
   input wire logic otg_feature_req,
   output var logic otg_feature_ack,
   output var logic otg_feature_stall,
   input wire logic bus_reset_seen,
   output var uoc_usb_drv_t usb_drv,
   output var logic [1:0] engine1_mode,
   output var logic [1:0] engine2_mode,
   output var logic engine1_speed,
   output var logic engine2_speed,
   output var logic [15:0] engine1_dev_desc_pointer,
   output var logic [15:0] engine2_dev_desc_pointer
);
   typedef struct packed {
      uoc_state_t st;
      logic [MS_CNT_W-1:0] tick_cnt;
      logic ms_tick;
      logic [7:0] cnt;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      uoc_axil_rsp_t rsp;
      logic [3:0] cmd;
      logic [31:0] arg;
      logic result_err;
      logic port_low;
      logic port_none;
      logic keep_on;
      logic [15:0] otg_desc;
      logic [15:0] desc1;
      logic [15:0] desc2;
      logic desc_rej;
      logic [1:0] eng1_mode;
      logic [1:0] eng2_mode;
      logic eng1_spd;
      logic eng2_spd;
      logic eng1_user_spd;
      logic eng2_user_spd;
      logic srp_low;
      logic id_prev;
      uoc_usb_drv_t drv;
      logic feat_ack;
      logic feat_stall;
   } uoc_ctrl_st_t;

   uoc_ctrl_st_t q, d;
   logic [3:0] pins;
   logic dp_s, dm_s, id_s, alone_s;
   logic id_fall;

   uoc_pin_sync #(.W(4)) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .pin_in({standalone_mode, role_id_pin, dm_in, dp_in}),
      .pin_out(pins)
   );

   assign dp_s = pins[0];
   assign dm_s = pins[1];
   assign id_s = pins[2];
   assign alone_s = pins[3];
   assign id_fall = q.id_prev && !id_s;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = val[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   always_comb begin
      logic go;
      logic wr;
      logic [31:0] wv;
      logic [7:0] ms;
      logic [7:0] sel;
      logic [31:0] rd;
      logic hit;
      go = 1'b0;
      wr = 1'b0;
      wv = '0;
      ms = q.arg[7:0];
      sel = q.arg[ARG_SEL_LSB +: 8];
      rd = '0;
      hit = 1'b1;
      d = q;
      d.id_prev = id_s;
      d.ms_tick = 1'b0;
      d.feat_ack = 1'b0;
      d.feat_stall = 1'b0;

      // Millisecond tick, restarted at each command start
      if (q.tick_cnt == MS_CNT_W'(MS_CYCLES - 1)) begin
         d.tick_cnt = '0;
         d.ms_tick = 1'b1; // RQ23
      end else begin
         d.tick_cnt = q.tick_cnt + 1'b1;
      end

      if (otg_feature_req) begin
         d.feat_stall = (q.otg_desc == '0); // RQ1
         d.feat_ack = (q.otg_desc != '0); // RQ2
      end

      // Write channel: address and data taken in either order
      if (axil_req.awvalid && q.rsp.awready) begin
         d.aw_have = 1'b1;
         d.aw_addr = axil_req.awaddr[7:0];
         d.rsp.awready = 1'b0;
      end
      if (axil_req.wvalid && q.rsp.wready) begin
         d.w_have = 1'b1;
         d.w_data = axil_req.wdata;
         d.w_strb = axil_req.wstrb;
         d.rsp.wready = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.rsp.bvalid = 1'b1;
         d.rsp.bresp = RESP_OKAY;
         wr = 1'b1;
         case (q.aw_addr)
            A_CMD: begin
               wv = merge({28'h0000000, q.cmd}, q.w_data, q.w_strb);
               // A command written while busy is dropped
               if (q.st == ST_IDLE) begin
                  d.cmd = wv[3:0];
                  go = 1'b1;
               end
            end
            A_ARG: d.arg = merge(q.arg, q.w_data, q.w_strb);
            A_STATUS, A_PORT: ;
            A_OTG_DESC: begin
               wv = merge({16'h0000, q.otg_desc}, q.w_data, q.w_strb);
               d.otg_desc = wv[15:0];
            end
            A_DESC1: begin
               wv = merge({16'h0000, q.desc1}, q.w_data, q.w_strb);
               if (q.eng1_mode == MODE_PERIPH && // RQ21
                   wv[DESC_CNT_LSB +: 4] == CFG_COUNT_ONE) begin // RQ22
                  d.desc1 = wv[15:0];
               end else begin
                  d.desc_rej = 1'b1;
               end
            end
            A_DESC2: begin
               wv = merge({16'h0000, q.desc2}, q.w_data, q.w_strb);
               if (q.eng2_mode == MODE_PERIPH && // RQ21
                   wv[DESC_CNT_LSB +: 4] == CFG_COUNT_ONE) begin // RQ22
                  d.desc2 = wv[15:0];
               end else begin
                  d.desc_rej = 1'b1;
               end
            end
            default: d.rsp.bresp = RESP_SLVERR;
         endcase
      end
      if (q.rsp.bvalid && axil_req.bready) begin
         d.rsp.bvalid = 1'b0;
         d.rsp.awready = 1'b1;
         d.rsp.wready = 1'b1;
      end

      // Read channel; status read clears the rejected-descriptor flag
      case (axil_req.araddr[7:0])
         A_CMD: rd = {28'h0000000, q.cmd};
         A_ARG: rd = q.arg;
         A_STATUS: rd = {23'h000000, q.desc_rej, q.eng2_spd, q.eng1_spd,
                         q.eng2_mode, q.eng1_mode, q.result_err,
                         q.st != ST_IDLE};
         A_PORT: rd = {30'h00000000, q.port_none, q.port_low}; // RQ16
         A_OTG_DESC: rd = {16'h0000, q.otg_desc};
         A_DESC1: rd = {16'h0000, q.desc1};
         A_DESC2: rd = {16'h0000, q.desc2};
         default: hit = 1'b0;
      endcase
      if (axil_req.arvalid && q.rsp.arready) begin
         d.rsp.arready = 1'b0;
         d.rsp.rvalid = 1'b1;
         d.rsp.rdata = rd;
         d.rsp.rresp = hit ? RESP_OKAY : RESP_SLVERR;
         // Rejection raised this cycle survives the read
         if (axil_req.araddr[7:0] == A_STATUS &&
             !(wr && d.desc_rej && !q.desc_rej)) begin
            d.desc_rej = 1'b0;
         end
      end
      if (q.rsp.rvalid && axil_req.rready) begin
         d.rsp.rvalid = 1'b0;
         d.rsp.arready = 1'b1;
      end

      if (bus_reset_seen) begin
         if (q.eng1_mode == MODE_PERIPH) d.eng1_spd = q.eng1_user_spd; // RQ20
         if (q.eng2_mode == MODE_PERIPH) d.eng2_spd = q.eng2_user_spd; // RQ20
      end

      case (q.st)
         ST_BOOT: begin
            // Wait for strap pins to pass the synchroniser
            if (q.cnt == '0) begin
               d.st = ST_IDLE;
               if (alone_s) begin
                  d.eng1_mode = id_s ? MODE_PERIPH : MODE_HOST; // RQ12
                  d.eng1_spd = SPEED_FULL; // RQ13
                  d.eng2_mode = MODE_PERIPH; // RQ13
                  d.eng2_spd = SPEED_FULL;
               end
            end else begin
               d.cnt = q.cnt - CNT_ONE;
            end
         end
         ST_IDLE: begin
            if (go) begin
               // Go edge already counts toward the first ms
               d.tick_cnt = MS_CNT_W'(CNT_ONE); // RQ23
               d.ms_tick = 1'b0;
               d.result_err = 1'b0;
               case (d.cmd)
                  OP_SRP: begin
                     // Out-of-range pulse time refused at once
                     if (ms == '0 || ms > SRP_MAX_MS) begin
                        d.result_err = 1'b1;
                     end else begin
                        d.st = ST_SRP_PULSE;
                        d.cnt = ms;
                        d.srp_low = q.arg[ARG_SPD_BIT]; // RQ5
                     end
                  end
                  OP_WAKE: begin
                     if ((sel == SEL_FIRST ? q.eng1_mode : q.eng2_mode)
                         != MODE_PERIPH) begin // RQ11
                        d.result_err = 1'b1;
                     end else begin
                        d.st = ST_WAKE;
                        d.cnt = WAKE_MS; // RQ10
                     end
                  end
                  OP_HRESET: begin
                     d.st = ST_RST_HOLD;
                     d.keep_on = 1'b0;
                     d.drv.port_sel = sel[1:0]; // RQ18
                     d.cnt = (ms < RESET_MIN_MS) ? RESET_MIN_MS : ms; // RQ14
                  end
                  OP_PERIPH: begin
                     if (sel == ENG_ONE) begin // RQ19
                        d.eng1_mode = MODE_PERIPH;
                        d.eng1_spd = q.arg[ARG_SPD_BIT];
                        d.eng1_user_spd = q.arg[ARG_SPD_BIT];
                     end else if (sel == ENG_TWO) begin
                        d.eng2_mode = MODE_PERIPH;
                        d.eng2_spd = q.arg[ARG_SPD_BIT];
                        d.eng2_user_spd = q.arg[ARG_SPD_BIT];
                     end else begin
                        d.result_err = 1'b1;
                     end
                  end
                  OP_HOST1: d.eng1_mode = MODE_HOST; // RQ12
                  OP_HOST2: d.eng2_mode = MODE_HOST;
                  default: d.result_err = 1'b1;
               endcase
            end
         end
         ST_SRP_PULSE: begin
            if (id_fall) begin
               d.st = ST_IDLE; // RQ6
               d.result_err = 1'b0;
            end else if (q.ms_tick) begin
               d.cnt = q.cnt - CNT_ONE;
               if (q.cnt == CNT_ONE) begin
                  d.st = ST_SRP_CHECK;
                  d.cnt = SETTLE_MS;
               end
            end
         end
         ST_SRP_CHECK: begin
            if (q.ms_tick) begin
               d.cnt = q.cnt - CNT_ONE;
               if (q.cnt == CNT_ONE) begin
                  d.st = ST_IDLE;
                  d.result_err = dp_s || dm_s; // RQ7
               end
            end
         end
         ST_WAKE: begin
            if (q.ms_tick) begin
               d.cnt = q.cnt - CNT_ONE;
               if (q.cnt == CNT_ONE) d.st = ST_IDLE;
            end
         end
         ST_RST_HOLD: begin
            if (q.ms_tick) begin
               d.cnt = q.cnt - CNT_ONE;
               if (q.cnt == CNT_ONE) begin
                  d.st = ST_SPEED;
                  d.cnt = SETTLE_MS;
               end
            end
         end
         ST_SPEED: begin
            // Idle line: D+ high full speed, D- high low speed
            if (q.ms_tick) begin
               d.cnt = q.cnt - CNT_ONE;
               if (q.cnt == CNT_ONE) begin
                  d.st = ST_IDLE;
                  d.port_low = !dp_s && dm_s; // RQ16
                  d.port_none = !dp_s && !dm_s;
                  d.keep_on = dp_s || dm_s; // RQ17
               end
            end
         end
         default: d.st = ST_IDLE;
      endcase

      d.drv.vbus_drive = q.st == ST_SRP_PULSE; // RQ3
      d.drv.dp_pullup = q.st == ST_SRP_PULSE && !q.srp_low; // RQ5
      d.drv.dm_pullup = q.st == ST_SRP_PULSE && q.srp_low; // RQ8
      d.drv.dp_pulldown = q.st == ST_SRP_CHECK; // RQ7
      d.drv.dm_pulldown = q.st == ST_SRP_CHECK;
      d.drv.drive_k = q.st == ST_WAKE; // RQ10
      d.drv.drive_se0 = q.st == ST_RST_HOLD || // RQ14
         (q.keep_on && q.port_low && q.ms_tick); // RQ17
      d.drv.sof_mark = q.keep_on && !q.port_low && q.ms_tick; // RQ17
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
         q.st <= ST_BOOT;
         q.cnt <= BOOT_CYC;
         q.rsp.awready <= 1'b1;
         q.rsp.wready <= 1'b1;
         q.rsp.arready <= 1'b1;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // Same flops the handshake logic uses, so ready seen equals ready acted on
   assign axil_rsp = q.rsp;
   assign otg_feature_ack = q.feat_ack;
   assign otg_feature_stall = q.feat_stall;
   assign usb_drv = q.drv;
   assign engine1_mode = q.eng1_mode;
   assign engine2_mode = q.eng2_mode;
   assign engine1_speed = q.eng1_spd;
   assign engine2_speed = q.eng2_spd;
   assign engine1_dev_desc_pointer = q.desc1;
   assign engine2_dev_desc_pointer = q.desc2;

   stall_gate_a: assert property ( // RQ1
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && otg_feature_req && q.otg_desc == '0
      |=> otg_feature_stall && !otg_feature_ack)
      else $error("feature request with empty pointer not stalled");

   ack_gate_a: assert property ( // RQ2
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && otg_feature_req && q.otg_desc != '0
      |=> otg_feature_ack && !otg_feature_stall)
      else $error("feature request with pointer not acknowledged");

   srp_pins_a: assert property ( // RQ3
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && q.st == ST_SRP_PULSE
      |=> usb_drv.vbus_drive && usb_drv.dm_pullup == $past(q.srp_low)
          && usb_drv.dp_pullup != $past(q.srp_low))
      else $error("session pulse drives wrong lines");

   id_abort_a: assert property ( // RQ6
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && q.st == ST_SRP_PULSE && id_fall
      |=> q.st == ST_IDLE && !q.result_err)
      else $error("ID fall did not abort session request");

   srp_check_a: assert property ( // RQ7
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && q.st == ST_SRP_CHECK && q.ms_tick && q.cnt == CNT_ONE
      |=> q.result_err == $past(dp_s || dm_s))
      else $error("line check result wrong");

   srp_off_a: assert property ( // RQ8
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && q.st == ST_IDLE
      |=> !usb_drv.vbus_drive && !usb_drv.dp_pullup && !usb_drv.dm_pullup)
      else $error("drives left on while idle");

   wake_len_a: assert property ( // RQ10
      @(posedge clk_sys) disable iff (!reset_n)
      $rose(q.st == ST_WAKE) |-> q.cnt == WAKE_MS)
      else $error("wakeup K length not loaded");

   reset_min_a: assert property ( // RQ14
      @(posedge clk_sys) disable iff (!reset_n)
      $rose(q.st == ST_RST_HOLD) |-> q.cnt >= RESET_MIN_MS)
      else $error("port reset shorter than minimum");

   keep_alive_a: assert property ( // RQ17
      @(posedge clk_sys) disable iff (!reset_n)
      usb_drv.sof_mark
      |-> $past(!q.port_low && !q.port_none && q.keep_on))
      else $error("SOF sent to low speed or empty port");

   desc_gate_a: assert property ( // RQ21
      @(posedge clk_sys) disable iff (!reset_n)
      $changed(q.desc1) |-> $past(q.eng1_mode) == MODE_PERIPH)
      else $error("descriptor taken before engine enabled");

   tick_once_a: assert property ( // RQ23
      @(posedge clk_sys) disable iff (!reset_n)
      clk_en && q.ms_tick |=> !q.ms_tick)
      else $error("millisecond tick longer than one cycle");
endmodule : uoc_port_ctrl
`default_nettype wire
